// *** verilog/csm_pkg.sv ***
// Operation
// RULE1: sleep gates clock, all activity frozen
// RULE2: software enters sleep only from reset/halt
// RULE3: writing sleep bit zero wakes, clocking resumes
// RULE4: wakeup returns to remembered reset or halt
// RULE5: software selects test mode only in halt
// RULE6: test mode 01b: listen-only, recessive output
// RULE7: listen-only drives no ack, overload, error flag
// RULE8: software requests no transmission in listen-only
// RULE9: test mode 10b: external loopback, self acknowledge
// RULE10: test mode 11b: internal loopback, self acknowledge
// RULE11: internal loopback ignores external receive pin
// RULE12: internal loopback holds transmit pin recessive
// RULE13: status confirms each completed mode switch
// RULE14: reset request waits for current frame end
// RULE15: test mode 00b: normal bus operation
package csm_pkg;
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] TXD_OFF = 8'h08;
  localparam logic [7:0] RXD_OFF = 8'h0c;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_SLEEP_BIT = 2;
  localparam int CTRL_TEST_LSB = 8;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_SLEEP_BIT = 2;
  localparam int STAT_DONE_BIT = 3;
  localparam int STAT_BUSY_BIT = 4;
  localparam int STAT_RXV_BIT = 5;
  localparam int STAT_TXFULL_BIT = 6;
  localparam int STAT_SELFACK_BIT = 7;
  localparam int DATA_W = 16;
  localparam int CLK_NS = 10;
  localparam int BIT_NS = 2000;
  localparam int BIT_CYC = BIT_NS / CLK_NS;
  localparam int MAX_FRAME_BITS = 160;
  typedef enum logic [1:0] {
    OP_OPERATE = 2'b00,
    OP_RESET = 2'b01,
    OP_HALT = 2'b10
  } csm_op_e;
  typedef enum logic [1:0] {
    TM_NORMAL = 2'b00,
    TM_LISTEN = 2'b01,
    TM_EXT_LOOP = 2'b10,
    TM_INT_LOOP = 2'b11
  } csm_test_e;
  typedef enum logic [1:0] {
    S_RESET = 2'b00,
    S_HALT = 2'b01,
    S_OPERATE = 2'b10,
    S_SLEEP = 2'b11
  } csm_state_e;
  typedef struct packed {
    csm_test_e test;
    logic sleep;
    csm_op_e op;
  } csm_ctrl_s;
  localparam csm_ctrl_s CTRL_RST = '{test: TM_NORMAL, sleep: 1'b0, op: OP_RESET};
endpackage

// *** verilog/csm_buf2.sv ***
`timescale 1ns/1ps
module csm_buf2 #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end
    else if (push)
    begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= ~wr_ptr_q;
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// *** verilog/csm_top.sv ***
`timescale 1ns/1ps
module csm_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_receive_pin,
  output logic bus_transmit_pin,
  output logic clk_gate_en
);
  csm_pkg::csm_ctrl_s ctrl_q;
  csm_pkg::csm_state_e state_q;
  csm_pkg::csm_state_e prior_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic rx_meta_q;
  logic rx_sync_q;
  logic [7:0] div_q;
  logic bit_tick;
  logic run;
  logic tx_active_q;
  logic [4:0] tx_cnt_q;
  logic [csm_pkg::DATA_W-1:0] tx_shift_q;
  logic tx_bit_q;
  logic rx_active_q;
  logic [4:0] rx_cnt_q;
  logic [csm_pkg::DATA_W-1:0] rx_shift_q;
  logic [csm_pkg::DATA_W-1:0] rx_data_q;
  logic rx_valid_q;
  logic ack_q;
  logic self_ack_q;
  logic own_q;
  logic [7:0] frame_bits_q;
  logic tx_pin_q;
  logic clk_en_q;
  logic frame_busy;
  logic rx_bit;
  logic access;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic txd_wr;
  logic txd_ok;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [csm_pkg::DATA_W-1:0] buf_out_data;
  logic rx_done;
  logic mode_done;
  logic [31:0] rd_mux;
  csm_pkg::csm_test_e tm;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign bus_transmit_pin = tx_pin_q;
  assign clk_gate_en = clk_en_q;
  assign tm = ctrl_q.test;

  // only the register interface (answers, sleep bit writes, RXD clearing reads) and the clock gate enable move while asleep
  assign run = (state_q != csm_pkg::S_SLEEP); // RULE1
  assign frame_busy = tx_active_q || rx_active_q;

  // one wait state: every access answers on its second access cycle
  assign access = psel && penable;
  assign wr_en = access && pready_q && pwrite;
  assign rd_en = access && !pready_q && !pwrite;
  assign addr_ok = (paddr == csm_pkg::CTRL_OFF) || (paddr == csm_pkg::STAT_OFF) ||
    (paddr == csm_pkg::TXD_OFF) || (paddr == csm_pkg::RXD_OFF);
  assign txd_ok = (paddr == csm_pkg::TXD_OFF) && buf_in_ready && run;
  assign txd_wr = wr_en && !pslverr_q && (paddr == csm_pkg::TXD_OFF);
  assign mode_done = (state_q == csm_pkg::S_SLEEP) ? ctrl_q.sleep :
    (state_q == csm_pkg::S_OPERATE) ? (ctrl_q.op == csm_pkg::OP_OPERATE) :
    (state_q == csm_pkg::S_HALT) ? (ctrl_q.op == csm_pkg::OP_HALT) :
    (ctrl_q.op == csm_pkg::OP_RESET);

  always_comb
  begin
    rd_mux = 32'h0;
    case (paddr)
      csm_pkg::CTRL_OFF:
      begin
        rd_mux[csm_pkg::CTRL_OP_LSB +: 2] = ctrl_q.op;
        rd_mux[csm_pkg::CTRL_SLEEP_BIT] = ctrl_q.sleep;
        rd_mux[csm_pkg::CTRL_TEST_LSB +: 2] = ctrl_q.test;
      end
      csm_pkg::STAT_OFF:
      begin
        rd_mux[csm_pkg::STAT_MODE_LSB +: 2] = state_q;
        rd_mux[csm_pkg::STAT_SLEEP_BIT] = !run;
        rd_mux[csm_pkg::STAT_DONE_BIT] = mode_done; // RULE13
        rd_mux[csm_pkg::STAT_BUSY_BIT] = frame_busy;
        rd_mux[csm_pkg::STAT_RXV_BIT] = rx_valid_q;
        rd_mux[csm_pkg::STAT_TXFULL_BIT] = !buf_in_ready;
        rd_mux[csm_pkg::STAT_SELFACK_BIT] = self_ack_q;
      end
      csm_pkg::RXD_OFF:
        rd_mux[csm_pkg::DATA_W-1:0] = rx_data_q;
      default:
        rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= access && !pready_q;
      if (access && !pready_q)
      begin
        pslverr_q <= !addr_ok || (pwrite && (paddr == csm_pkg::TXD_OFF) && !txd_ok);
        prdata_q <= rd_en ? rd_mux : 32'h0;
      end
      else
      begin
        // answer fields stand for the answer cycle only
        pslverr_q <= 1'b0;
        prdata_q <= 32'h0;
      end
    end
  end

  // control register: op select is ignored asleep, test mode only in halt
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ctrl_q <= csm_pkg::CTRL_RST;
    else if (wr_en && (paddr == csm_pkg::CTRL_OFF))
    begin
      if (run && (pwdata[csm_pkg::CTRL_OP_LSB +: 2] != 2'b11))
        ctrl_q.op <= csm_pkg::csm_op_e'(pwdata[csm_pkg::CTRL_OP_LSB +: 2]);
      if (state_q == csm_pkg::S_HALT)
        ctrl_q.test <= csm_pkg::csm_test_e'(pwdata[csm_pkg::CTRL_TEST_LSB +: 2]); // RULE5
      if (!pwdata[csm_pkg::CTRL_SLEEP_BIT])
        ctrl_q.sleep <= 1'b0; // RULE3
      else if ((state_q == csm_pkg::S_RESET) || (state_q == csm_pkg::S_HALT))
        ctrl_q.sleep <= 1'b1; // RULE2
    end
  end

  // mode machine
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= csm_pkg::S_RESET;
      prior_q <= csm_pkg::S_RESET;
    end
    else
    begin
      case (state_q)
        csm_pkg::S_SLEEP:
          if (!ctrl_q.sleep)
            state_q <= prior_q; // RULE3 RULE4
        csm_pkg::S_OPERATE:
          // leaving mid-frame would corrupt the bus, so the frame runs out first
          if ((ctrl_q.op != csm_pkg::OP_OPERATE) && !frame_busy) // RULE14
            state_q <= (ctrl_q.op == csm_pkg::OP_RESET) ? csm_pkg::S_RESET : csm_pkg::S_HALT;
        default:
          if (ctrl_q.sleep)
          begin
            prior_q <= state_q; // RULE4
            state_q <= csm_pkg::S_SLEEP; // RULE2
          end
          else if (ctrl_q.op == csm_pkg::OP_OPERATE)
            state_q <= csm_pkg::S_OPERATE;
          else if (ctrl_q.op == csm_pkg::OP_HALT)
            state_q <= csm_pkg::S_HALT;
          else
            state_q <= csm_pkg::S_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      clk_en_q <= 1'b1;
    else
      clk_en_q <= (state_q != csm_pkg::S_SLEEP) || !ctrl_q.sleep; // RULE1
  end

  // receive pin synchroniser, only the second stage is read
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end
    else if (run)
    begin
      rx_meta_q <= bus_receive_pin;
      rx_sync_q <= rx_meta_q;
    end
  end

  // bit rate divider
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      div_q <= 8'h0;
    else if (!run)
      div_q <= div_q; // RULE1
    else if (div_q == 8'(csm_pkg::BIT_CYC - 1))
      div_q <= 8'h0;
    else
      div_q <= div_q + 8'h1;
  end
  assign bit_tick = run && (div_q == 8'(csm_pkg::BIT_CYC - 1));

  // internal loopback takes the engine's own transmit bit
  assign rx_bit = (tm == csm_pkg::TM_INT_LOOP) ? tx_bit_q : rx_sync_q; // RULE10 RULE11

  csm_buf2 #(
    .W(csm_pkg::DATA_W)
  ) u_txbuf (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(txd_wr),
    .in_ready(buf_in_ready),
    .in_data(pwdata[csm_pkg::DATA_W-1:0]),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  // listen-only never starts a frame; a write there just waits in the buffer
  assign buf_out_ready = bit_tick && (state_q == csm_pkg::S_OPERATE) && !frame_busy &&
    (ctrl_q.op == csm_pkg::OP_OPERATE) && (tm != csm_pkg::TM_LISTEN) && rx_bit; // RULE8

  // transmitter: start bit, then data msb first, then a recessive ack slot
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_active_q <= 1'b0;
      tx_cnt_q <= 5'h0;
      tx_shift_q <= '0;
      tx_bit_q <= 1'b1;
    end
    else if (state_q != csm_pkg::S_OPERATE)
    begin
      if (run)
      begin
        tx_active_q <= 1'b0;
        tx_bit_q <= 1'b1;
      end
    end
    else if (bit_tick)
    begin
      if (buf_out_valid && buf_out_ready)
      begin
        tx_active_q <= 1'b1;
        tx_cnt_q <= 5'h0;
        tx_shift_q <= buf_out_data;
        tx_bit_q <= 1'b0;
      end
      else if (tx_active_q && (tx_cnt_q < 5'(csm_pkg::DATA_W)))
      begin
        tx_bit_q <= tx_shift_q[csm_pkg::DATA_W-1];
        tx_shift_q <= {tx_shift_q[csm_pkg::DATA_W-2:0], 1'b1};
        tx_cnt_q <= tx_cnt_q + 5'h1;
      end
      else if (tx_active_q && (tx_cnt_q == 5'(csm_pkg::DATA_W)))
      begin
        tx_bit_q <= 1'b1;
        tx_cnt_q <= tx_cnt_q + 5'h1;
      end
      else
        tx_active_q <= 1'b0;
    end
  end

  // receiver samples one bit behind the transmitter
  assign rx_done = bit_tick && rx_active_q && (rx_cnt_q == 5'(csm_pkg::DATA_W - 1));

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_active_q <= 1'b0;
      rx_cnt_q <= 5'h0;
      rx_shift_q <= '0;
      own_q <= 1'b0;
      frame_bits_q <= 8'h0;
    end
    else if (state_q != csm_pkg::S_OPERATE)
    begin
      if (run)
        rx_active_q <= 1'b0;
    end
    else if (bit_tick)
    begin
      if (!rx_active_q && !rx_bit && !ack_q)
      begin
        rx_active_q <= 1'b1;
        rx_cnt_q <= 5'h0;
        own_q <= tx_active_q;
        frame_bits_q <= 8'h0;
      end
      else if (rx_active_q)
      begin
        rx_shift_q <= {rx_shift_q[csm_pkg::DATA_W-2:0], rx_bit};
        rx_cnt_q <= rx_cnt_q + 5'h1;
        frame_bits_q <= frame_bits_q + 8'h1;
        // a frame can never outlast the longest legal one
        if (rx_done || (frame_bits_q == 8'(csm_pkg::MAX_FRAME_BITS - 1))) // RULE14
          rx_active_q <= 1'b0;
      end
    end
  end

  // received word and its flag; a new frame wins over the clearing read
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_data_q <= '0;
      rx_valid_q <= 1'b0;
      self_ack_q <= 1'b0;
    end
    else if (rx_done && (!own_q || (tm == csm_pkg::TM_EXT_LOOP) ||
      (tm == csm_pkg::TM_INT_LOOP))) // RULE6 RULE9 RULE10 RULE15
    begin
      rx_data_q <= {rx_shift_q[csm_pkg::DATA_W-2:0], rx_bit};
      rx_valid_q <= 1'b1;
      self_ack_q <= own_q; // RULE9 RULE10
    end
    else if (rd_en && (paddr == csm_pkg::RXD_OFF))
      rx_valid_q <= 1'b0;
  end

  // ack slot: only a normal node acknowledges a frame of another node
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ack_q <= 1'b0;
    else if (bit_tick)
      ack_q <= rx_done && !own_q && (tm == csm_pkg::TM_NORMAL); // RULE7 RULE15
  end

  // pin driver
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      tx_pin_q <= 1'b1;
    else if (run)
    begin
      case (tm)
        csm_pkg::TM_LISTEN:
          tx_pin_q <= 1'b1; // RULE6 RULE7
        csm_pkg::TM_INT_LOOP:
          tx_pin_q <= 1'b1; // RULE12
        default:
          tx_pin_q <= tx_bit_q && !ack_q; // RULE9 RULE15
      endcase
    end
  end
endmodule

// *** verif/csm_top_sva.sv ***
`timescale 1ns/1ps
module csm_top_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bus_receive_pin,
  input wire logic bus_transmit_pin,
  input wire logic clk_gate_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  csm_pkg::csm_test_e test_q;
  // followed from accepted control writes; outside halt they carry the field unchanged
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      test_q <= csm_pkg::TM_NORMAL;
    else if (pready && pwrite && !pslverr && paddr == csm_pkg::CTRL_OFF)
      test_q <= csm_pkg::csm_test_e'(pwdata[9:8]);
  end
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_wake;
    pready && pwrite && paddr == csm_pkg::CTRL_OFF && !pwdata[2] && !clk_gate_en;
  endsequence
  a_ready_wait: assert property (s_access |=> pready)
    else $error("no answer one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("answer held over one cycle");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("answer without access");
  a_bad_addr: assert property (pready && paddr > 8'h0c |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside answer");
  a_wake_resume: assert property (s_wake |-> ##[1:4] clk_gate_en)
    else $error("clock not resumed after wake");
  a_sleep_silent: assert property (!clk_gate_en |-> bus_transmit_pin)
    else $error("bus driven while asleep");
  a_txd_asleep: assert property (pready && pwrite && paddr == csm_pkg::TXD_OFF && !clk_gate_en |-> pslverr)
    else $error("word taken while asleep");
  a_quiet_modes: assert property (test_q inside {csm_pkg::TM_LISTEN, csm_pkg::TM_INT_LOOP} |-> bus_transmit_pin)
    else $error("dominant bit in quiet mode");
endmodule
bind csm_top csm_top_chk chk_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .bus_receive_pin(bus_receive_pin), .bus_transmit_pin(bus_transmit_pin),
  .clk_gate_en(clk_gate_en));

// *** verif/csm_can_node.sv ***
`timescale 1ns/1ps
module csm_can_node (
  input wire logic clk,
  input wire logic bus_transmit_pin,
  input wire logic hold_dom,
  output logic bus_receive_pin,
  output logic ack_seen
);
  logic drv;
  // wired-and bus seen through the transceiver, so own bits echo back
  assign bus_receive_pin = bus_transmit_pin & drv & !hold_dom;
  initial
  begin
    drv = 1'b1;
    ack_seen = 1'b0;
  end
  // the receiver samples at its own phase, so its ack may start inside the last data bit
  task automatic send(input logic [15:0] d);
    logic [17:0] f;
    f = {1'b0, d, 1'b1};
    ack_seen = 1'b0;
    for (int i = 17; i >= 0; i--)
    begin
      drv <= f[i];
      for (int c = 0; c < csm_pkg::BIT_CYC; c++)
      begin
        @(posedge clk);
        if ((i < 2) && !bus_transmit_pin)
          ack_seen = 1'b1;
      end
    end
    drv <= 1'b1;
  endtask
endmodule

// *** verif/csm_top_tb_top.sv ***
`timescale 1ns/1ps
module csm_top_tb_top;
  localparam logic [7:0] CA = csm_pkg::CTRL_OFF;
  localparam logic [7:0] SA = csm_pkg::STAT_OFF;
  localparam logic [7:0] TA = csm_pkg::TXD_OFF;
  localparam logic [7:0] RA = csm_pkg::RXD_OFF;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, rx, tx, gate, hold_dom, ack_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [32:0] exp_q[$], msk_q[$];
  logic [15:0] w[2];
  int errors, check_count, n;
  csm_top dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_receive_pin(rx), .bus_transmit_pin(tx), .clk_gate_en(gate));
  csm_can_node node_u (.clk(clk), .bus_transmit_pin(tx), .hold_dom(hold_dom),
    .bus_receive_pin(rx), .ack_seen(ack_seen));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] cw(input logic [1:0] tm, input logic sl, input logic [1:0] op);
    return {22'h0, tm, 5'h0, sl, op};
  endfunction
  task automatic check(input logic [32:0] got, input logic [32:0] want);
    check_count++;
    if (got !== want)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, want);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one idle cycle between transfers keeps each signal to one assignment per step
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e, input logic [32:0] m);
    int k;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (!pready && k < 50);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (!pready)
    begin
      errors++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d, {e, 32'h0}, 33'h1_0000_0000);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    apb(1'b0, a, 32'h0, {1'b0, v}, {1'b1, m});
  endtask
  task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
    int k;
    k = 0;
    do
    begin
      rdc(SA, 32'h0, 32'h0);
      k++;
    end
    while ((rd & m) !== v && k < 3000);
    if ((rd & m) !== v)
    begin
      errors++;
      finish_test();
    end
  endtask
  task automatic mode(input logic [1:0] st);
    wait_stat(32'h0b, {28'h0, 2'b10, st});
    rdc(SA, 32'h0f, {28'h0, 1'b1, st == 2'b11, st});
  endtask
  always @(posedge clk)
  begin
    if (pready && psel && penable && exp_q.size() > 0)
      check({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
  end
  initial
  begin
    {sys_rst, psel, penable, pwrite, hold_dom} = 5'h10;
    paddr = 8'h0;
    pwdata = 32'h0;
    errors = 0;
    check_count = 0;
    void'($urandom(32'h0237));
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(CA, 32'h0000_0307, 32'h0000_0001);
    mode(2'b00);
    apb(1'b0, 8'h10, 32'h0, 33'h1_0000_0000, 33'h1_ffff_ffff);
    wr(8'h14, 32'h1, 1'b1);
    check({32'h0, gate}, 33'h1);
    $display("reset and map test done");
    for (int i = 1; i < 3; i++)
    begin
      wr(CA, cw(2'b00, 1'b0, i[1:0]), 1'b0);
      mode(i[1:0] - 2'b01);
      wr(CA, cw(2'b00, 1'b1, i[1:0]), 1'b0);
      mode(2'b11);
      check({32'h0, gate}, 33'h0);
      wr(TA, $urandom, 1'b1);
      wr(CA, cw(2'b00, 1'b0, i[1:0]), 1'b0);
      mode(i[1:0] - 2'b01);
      check({32'h0, gate}, 33'h1);
    end
    $display("sleep and wake test done");
    for (int t = 0; t < 4; t++)
    begin
      wr(CA, cw(t[1:0], 1'b0, 2'b10), 1'b0);
      hold_dom <= (t == 3);
      n = (t == 2) ? 2 : (t == 3);
      for (int k = 0; k < n; k++)
      begin
        w[k] = 16'($urandom);
        wr(TA, {16'h0, w[k]}, 1'b0);
      end
      if (t == 2)
      begin
        wr(TA, $urandom, 1'b1);
        rdc(SA, 32'h40, 32'h40);
      end
      wr(CA, cw(t[1:0], 1'b0, 2'b00), 1'b0);
      mode(2'b10);
      if (t < 2)
      begin
        n = 1;
        w[0] = 16'($urandom);
        node_u.send(w[0]);
        check({32'h0, ack_seen}, {32'h0, t == 0});
      end
      for (int k = 0; k < n; k++)
      begin
        wait_stat(32'h20, 32'h20);
        rdc(RA, 32'hffff, {16'h0, w[k]});
        rdc(SA, 32'h80, {24'h0, t > 1, 7'h0});
      end
      hold_dom <= 1'b0;
      wr(CA, cw(t[1:0], 1'b0, 2'b10), 1'b0);
      mode(2'b01);
    end
    $display("test mode sweep done");
    wr(CA, cw(2'b00, 1'b0, 2'b10), 1'b0);
    wr(CA, cw(2'b00, 1'b0, 2'b00), 1'b0);
    mode(2'b10);
    w[0] = 16'($urandom);
    fork
      node_u.send(w[0]);
      begin
        wait_stat(32'h10, 32'h10);
        wr(CA, cw(2'b00, 1'b0, 2'b01), 1'b0);
        rdc(SA, 32'h0b, 32'h02);
      end
    join
    mode(2'b00);
    $display("reset during frame test done");
    finish_test();
  end
endmodule
